// *** core/slc_defs.svh ***
// constants of the sleep-mode controller: modes, field positions, timing
`ifndef SLC_DEFS_SVH
`define SLC_DEFS_SVH
`define SLC_CLK_NS 100
`define SLC_MODE_IDLE 3'h0
`define SLC_MODE_PDOWN 3'h2
`define SLC_MODE_PSAVE 3'h3
`define SLC_MODE_STBY 3'h6
`define SLC_MODE_XSTBY 3'h7
`define SLC_CTRL_RESET 4'h0
`define SLC_CTRL_ARM_BIT 0
`define SLC_CTRL_MODE_LSB 1
`define SLC_CLOCK_SELECT_FUSES_RC 4'h2
`define SLC_STARTUP_NS 1000
`define SLC_STBY_WAKE_CYC 6
`define SLC_WAKE_HALT_CYC 4
`define SLC_PLL_LOCK_US 2000
`define SLC_SRC_UPPER_LSB 4
`define SLC_SRC_PIN 8
`define SLC_SRC_SPM 9
`define SLC_SRC_WDT 10
`define SLC_SRC_IO 11
`define SLC_SRC_CMP 12
`define SLC_SRC_USB_SYNC 13
`define SLC_SRC_USB_WAKE 14
`define SLC_SRC_TWI 15
`endif

// *** core/slc_pkg.sv ***
// types of the sleep-mode controller
package slc_pkg;
  // controller sequence
  typedef enum logic [1:0] {
    st_run,
    st_sleep,
    st_start,
    st_halt
  } slc_state_t;

  // whole state of the device end
  typedef struct packed {
    slc_state_t st;
    logic [15:0] cnt;      // start-up and halt countdown
    logic [3:0] ctrl;      // sleep_control_reg: mode[3:1], arm[0]
    logic deep;            // sleeping in a deep mode
    logic stby;            // oscillator kept running
    logic pll_on;          // pll_on_request
    logic mux;             // pll_source_mux
    logic lock;            // pll_locked_flag
    logic [15:0] lock_cnt; // lock timer
    logic cpu_en;
    logic flash_en;
    logic io_en;
    logic osc_en;
    logic rc_en;
    logic cmp_on;
    logic halt;
    logic resume;          // pulse: run isr then continue after sleep
    logic rst_vec;         // pulse: restart at reset vector
    logic rst_pend;        // a reset arrived while asleep
  } slc_dev_t;

  // whole state of the core end
  typedef struct packed {
    logic sleep_instr;
    logic ctrl_wr;
    logic [3:0] ctrl_wdata;
    logic pll_wr;
    logic pll_wdata;
    logic pll_mux;
    logic cmp_off;
    logic [15:0] src;
    logic [3:0] lvl;
    logic [2:0] rst;
    logic halted;
    logic isr;
    logic rstv;
    logic [3:0] ctrl_rd;
    logic lock_rd;
  } slc_core_t;
endpackage : slc_pkg

// *** core/slc_if.sv ***
// link between the processor core end and the sleep controller end
`timescale 1ns/10ps
`default_nettype none
interface slc_if;
  logic sleep_instr;     // core executes a sleep instruction
  logic ctrl_wr;         // write sleep_control_reg
  logic [3:0] ctrl_wdata;
  logic pll_wr;          // write pll_on_request and pll_source_mux
  logic pll_wdata;
  logic pll_mux;
  logic cmp_off;         // comparator_power_off
  logic [15:0] src;      // interrupt request levels
  logic [3:0] lvl;       // upper lines set level-sensitive
  logic [2:0] rst;       // external, watchdog, brown-out reset
  logic [3:0] ctrl_rd;
  logic lock;
  logic halt;
  logic resume;
  logic rst_vec;
  modport dev (
    input sleep_instr, ctrl_wr, ctrl_wdata, pll_wr, pll_wdata, pll_mux, cmp_off, src, lvl, rst,
    output ctrl_rd, lock, halt, resume, rst_vec
  );
  modport cpu (
    output sleep_instr, ctrl_wr, ctrl_wdata, pll_wr, pll_wdata, pll_mux, cmp_off, src, lvl, rst,
    input ctrl_rd, lock, halt, resume, rst_vec
  );
endinterface : slc_if
`default_nettype wire

// *** core/slc_device.sv ***
// sleep-mode controller: clock gating, wake filtering and wake timing
//
// Contract
// - sleep only when armed plus instruction
// - mode 000 idle stops cpu, flash
// - idle wakes on every enabled source
// - mode 010 power-down stops all clocks
// - power-down wakes on listed sources only
// - deep modes: upper lines wake on level
// - usb wake only async deep source
// - power-down wake waits full start-up
// - mode 011 acts like power-down
// - mode 110 with crystal keeps oscillator
// - standby wakes after six cycles
// - standby only with crystal clock source
// - interrupt wake halts four extra cycles
// - register file and sram untouched
// - reset in sleep restarts at vector
// - level wake held long enough externally
// - comparator power-off removes idle source
// - pll enable starts pll; rc osc only while the mux picks it
// - software clears pll before power-down
// - lock flag after delay, cleared when pll switched off
// - mode 111 extended standby, six cycles
// - reserved codes; register resets to zero
`timescale 1ns/10ps
`default_nettype none
`include "slc_defs.svh"
module slc_device #(
  parameter int PLL_LOCK_US = `SLC_PLL_LOCK_US
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  slc_if.dev bus,
  input wire logic [3:0] i_clock_select_fuses,
  output logic o_clk_cpu_en,
  output logic o_clk_flash_en,
  output logic o_clk_io_en,
  output logic o_osc_en,
  output logic o_rc_osc_en,
  output logic o_pll_en,
  output logic o_cmp_power,
  output logic o_sleeping
);
  // least times round up to whole cycles
  localparam int STARTUP_CYC = (`SLC_STARTUP_NS + `SLC_CLK_NS - 1) / `SLC_CLK_NS;
  localparam int PLL_LOCK_CYC = (PLL_LOCK_US * 1000 + `SLC_CLK_NS - 1) / `SLC_CLK_NS;

  slc_pkg::slc_dev_t q, d;
  logic [2:0] mode;   // sleep_mode_select
  logic xtal;         // crystal or resonator chosen by fuses
  logic valid_mode;   // code names a real sleep mode
  logic wake_idle;    // permitted idle wake request
  logic wake_deep;    // permitted deep-mode wake request
  logic any_rst;      // any reset source

  ////////////////////////////////////////////////////////////////////
  // wake filters
  always_comb begin
    mode = q.ctrl[`SLC_CTRL_MODE_LSB +: 3];
    xtal = i_clock_select_fuses != `SLC_CLOCK_SELECT_FUSES_RC;
    valid_mode = (mode == `SLC_MODE_IDLE) || (mode == `SLC_MODE_PDOWN) || (mode == `SLC_MODE_PSAVE)
      || (mode == `SLC_MODE_STBY) || (mode == `SLC_MODE_XSTBY);
    // idle takes everything, minus a powered-off comparator
    wake_idle = |(bus.src & ~(16'h1 << `SLC_SRC_CMP)) || (bus.src[`SLC_SRC_CMP] && !bus.cmp_off);
    // deep modes: lower lines, level on upper lines, pin change, watchdog, usb wake, two-wire match
    wake_deep = |bus.src[3:0]
      || |(bus.src[`SLC_SRC_UPPER_LSB +: 4] & bus.lvl)
      || bus.src[`SLC_SRC_PIN] || bus.src[`SLC_SRC_WDT] || bus.src[`SLC_SRC_TWI]
      || bus.src[`SLC_SRC_USB_WAKE];
    any_rst = |bus.rst;
  end

  ////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    d = q;
    d.resume = 1'b0;
    d.rst_vec = 1'b0;
    // register writes from the core
    if (bus.ctrl_wr) begin
      d.ctrl = bus.ctrl_wdata;
    end
    if (bus.pll_wr) begin
      d.pll_on = bus.pll_wdata;
      d.mux = bus.pll_mux;
    end
    // rc oscillator follows the pll while the mux picks it; stays on in
    // power-down too, which is why software must drop the pll first
    d.rc_en = d.pll_on && d.mux;
    // lock timer restarts whenever the pll is switched off
    if (!q.pll_on) begin
      d.lock = 1'b0;
      d.lock_cnt = 16'h0;
    end else if (q.lock_cnt == 16'(PLL_LOCK_CYC - 1)) begin
      d.lock = 1'b1;
    end else begin
      d.lock_cnt = q.lock_cnt + 16'h1;
    end
    // comparator is off when asked, and in every deep mode
    d.cmp_on = !bus.cmp_off && !q.deep;
    case (q.st)
      slc_pkg::st_run: begin
        if (any_rst) begin
          d.rst_vec = 1'b1;
        end else if (bus.sleep_instr && q.ctrl[`SLC_CTRL_ARM_BIT] && valid_mode) begin
          d.st = slc_pkg::st_sleep;
          d.halt = 1'b1;
          d.cpu_en = 1'b0;
          d.flash_en = 1'b0;
          if (mode == `SLC_MODE_IDLE) begin
            d.deep = 1'b0;
            d.stby = 1'b0;
          end else begin
            // standby without a crystal falls back to power-down
            d.deep = 1'b1;
            d.io_en = 1'b0;
            d.stby = mode[2] && xtal;
            d.osc_en = mode[2] && xtal;
          end
        end
      end
      slc_pkg::st_sleep: begin
        // requests not allowed in this mode are simply not looked at
        if (any_rst || (q.deep ? wake_deep : wake_idle)) begin
          d.rst_pend = any_rst;
          d.osc_en = 1'b1;
          if (!q.deep) begin
            d.st = slc_pkg::st_halt;
            d.cpu_en = 1'b1;
            d.flash_en = 1'b1;
            d.cnt = 16'(`SLC_WAKE_HALT_CYC - 1);
          end else begin
            d.st = slc_pkg::st_start;
            d.cnt = q.stby ? 16'(`SLC_STBY_WAKE_CYC - 1) : 16'(STARTUP_CYC - 1);
          end
        end
      end
      slc_pkg::st_start: begin
        if (any_rst) begin
          d.rst_pend = 1'b1;
        end
        if (q.cnt == 16'h0) begin
          d.st = slc_pkg::st_halt;
          d.io_en = 1'b1;
          d.cpu_en = 1'b1;
          d.flash_en = 1'b1;
          d.deep = 1'b0;
          d.stby = 1'b0;
          d.cnt = 16'(`SLC_WAKE_HALT_CYC - 1);
        end else begin
          d.cnt = q.cnt - 16'h1;
        end
      end
      slc_pkg::st_halt: begin
        if (any_rst) begin
          d.rst_pend = 1'b1;
        end
        if (q.cnt == 16'h0) begin
          // core state was never touched; resume or restart only
          d.st = slc_pkg::st_run;
          d.halt = 1'b0;
          d.resume = !(q.rst_pend || any_rst);
          d.rst_vec = q.rst_pend || any_rst;
          d.rst_pend = 1'b0;
        end else begin
          d.cnt = q.cnt - 16'h1;
        end
      end
      default: begin
        d.st = slc_pkg::st_run;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // state register; control register clears to idle, disarmed
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= '0;
      q.ctrl <= `SLC_CTRL_RESET;
      q.st <= slc_pkg::st_run;
      q.cpu_en <= 1'b1;
      q.flash_en <= 1'b1;
      q.io_en <= 1'b1;
      q.osc_en <= 1'b1;
      q.cmp_on <= 1'b1;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  assign bus.ctrl_rd = q.ctrl;
  assign bus.lock = q.lock;
  assign bus.halt = q.halt;
  assign bus.resume = q.resume;
  assign bus.rst_vec = q.rst_vec;
  assign o_clk_cpu_en = q.cpu_en;
  assign o_clk_flash_en = q.flash_en;
  assign o_clk_io_en = q.io_en;
  assign o_osc_en = q.osc_en;
  assign o_rc_osc_en = q.rc_en;
  assign o_pll_en = q.pll_on;
  assign o_cmp_power = q.cmp_on;
  assign o_sleeping = q.halt;
endmodule : slc_device
`default_nettype wire

// *** core/slc_core.sv ***
// processor core end: issues sleep, writes control bits, forwards requests
`timescale 1ns/10ps
`default_nettype none
`include "slc_defs.svh"
module slc_core (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  slc_if.cpu bus,
  input wire logic i_sleep_exec,
  input wire logic i_ctrl_wr,
  input wire logic [3:0] i_ctrl_data,
  input wire logic i_pll_wr,
  input wire logic i_pll_data,
  input wire logic i_pll_mux,
  input wire logic i_cmp_off,
  input wire logic [15:0] i_src,
  input wire logic [3:0] i_lvl,
  input wire logic [2:0] i_rst,
  output logic o_halted,
  output logic o_isr,
  output logic o_rst_vec,
  output logic [3:0] o_ctrl_rd,
  output logic o_lock_rd
);
  slc_pkg::slc_core_t q, d;

  ////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    d = q;
    // a halted core executes nothing; one sleep per halt window
    d.sleep_instr = i_sleep_exec && !bus.halt && !q.sleep_instr && !q.halted;
    d.ctrl_wr = i_ctrl_wr && !bus.halt;
    d.ctrl_wdata = i_ctrl_data;
    d.pll_wr = i_pll_wr && !bus.halt;
    d.pll_wdata = i_pll_data;
    d.pll_mux = i_pll_mux;
    d.cmp_off = i_cmp_off;
    // level requests pass as levels; holding them is the source's job
    d.src = i_src;
    d.lvl = i_lvl;
    d.rst = i_rst;
    // the issued pulse bridges the edge before the controller's halt arrives,
    // so the halted level has no one-cycle dip on sleep entry
    d.halted = bus.halt || d.sleep_instr || q.sleep_instr;
    d.isr = bus.resume;
    d.rstv = bus.rst_vec;
    d.ctrl_rd = bus.ctrl_rd;
    d.lock_rd = bus.lock;
  end

  ////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs
  assign bus.sleep_instr = q.sleep_instr;
  assign bus.ctrl_wr = q.ctrl_wr;
  assign bus.ctrl_wdata = q.ctrl_wdata;
  assign bus.pll_wr = q.pll_wr;
  assign bus.pll_wdata = q.pll_wdata;
  assign bus.pll_mux = q.pll_mux;
  assign bus.cmp_off = q.cmp_off;
  assign bus.src = q.src;
  assign bus.lvl = q.lvl;
  assign bus.rst = q.rst;
  assign o_halted = q.halted;
  assign o_isr = q.isr;
  assign o_rst_vec = q.rstv;
  assign o_ctrl_rd = q.ctrl_rd;
  assign o_lock_rd = q.lock_rd;
endmodule : slc_core
`default_nettype wire

// *** verification/slc_asserts.sv ***
// concurrent checks on the link between core end and controller end
`timescale 1ns/10ps
`default_nettype none
`include "slc_defs.svh"
module slc_asserts #(
  parameter int PLL_LOCK_US = `SLC_PLL_LOCK_US
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic sleep_instr,
  input wire logic ctrl_wr,
  input wire logic [3:0] ctrl_wdata,
  input wire logic pll_wr,
  input wire logic pll_wdata,
  input wire logic cmp_off,
  input wire logic [15:0] src,
  input wire logic [3:0] lvl,
  input wire logic [2:0] rst,
  input wire logic [3:0] ctrl_rd,
  input wire logic lock,
  input wire logic halt,
  input wire logic resume,
  input wire logic rst_vec
);
  localparam int LOCK_CYC = PLL_LOCK_US * 1000 / `SLC_CLK_NS;
  ////////////////////////////////////////////////////////////////////////////
  logic [2:0] mode; // selected sleep mode
  logic idle_m, pd_m, wake_now, armed_ok;
  logic sleep_q; // asleep with no wake seen yet
  logic [15:0] age_q; // cycles since pll switched on
  assign mode = ctrl_rd[3:1];
  assign idle_m = mode == `SLC_MODE_IDLE;
  assign pd_m = mode == `SLC_MODE_PDOWN || mode == `SLC_MODE_PSAVE;
  // comparator only counts while it is powered
  assign wake_now = (rst != 3'h0) || (idle_m ? ((|src[11:0]) || (|src[15:13]) || (src[12] && !cmp_off))
    : ((|src[3:0]) || (|(src[7:4] & lvl)) || src[8] || src[10] || src[14] || src[15]));
  assign armed_ok = ctrl_rd[0] && (idle_m || pd_m || mode[2:1] == 2'h3);
  // track the sleep phase and the pll age; age saturates so it never wraps
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sleep_q <= 1'b0;
      age_q <= 16'h0;
    end else begin
      if (sleep_instr && !halt && armed_ok && rst == 3'h0) sleep_q <= 1'b1;
      else if (wake_now) sleep_q <= 1'b0;
      if (pll_wr) age_q <= {15'h0, pll_wdata};
      else if (age_q != 16'h0 && age_q != 16'hffff) age_q <= age_q + 16'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  property p_enter; sleep_instr && !halt && armed_ok && rst == 3'h0 |=> halt; endproperty
  a_enter: assert property (p_enter) else $error("sleep entry missed");
  property p_refuse; sleep_instr && !halt && !armed_ok |=> !halt; endproperty
  a_refuse: assert property (p_refuse) else $error("refused sleep entered");
  property p_idle_wake; sleep_q && wake_now && idle_m && rst == 3'h0 |=> halt[*4] ##1 (!halt && resume); endproperty
  a_idle_wake: assert property (p_idle_wake) else $error("idle wake timing wrong");
  property p_deep_wake;
    sleep_q && wake_now && pd_m && rst == 3'h0 |=> halt[*8] ##1 halt[*6] ##1 (!halt && resume);
  endproperty
  a_deep_wake: assert property (p_deep_wake) else $error("deep wake timing wrong");
  property p_quiet; sleep_q && !wake_now |=> halt; endproperty
  a_quiet: assert property (p_quiet) else $error("woke without a permitted source");
  property p_wake_end; $fell(halt) |-> resume != rst_vec; endproperty
  a_wake_end: assert property (p_wake_end) else $error("wake end without one restart pulse");
  property p_run_reset; !halt && rst != 3'h0 |=> rst_vec; endproperty
  a_run_reset: assert property (p_run_reset) else $error("reset without vector restart");
  property p_ctrl; ctrl_wr |=> ctrl_rd == $past(ctrl_wdata); endproperty
  a_ctrl: assert property (p_ctrl) else $error("control write lost");
  property p_lock_rise; $rose(lock) |-> age_q == 16'(LOCK_CYC + 1); endproperty
  a_lock_rise: assert property (p_lock_rise) else $error("lock flag at wrong time");
  property p_lock_clear; pll_wr && !pll_wdata |-> ##2 !lock; endproperty
  a_lock_clear: assert property (p_lock_clear) else $error("lock kept after pll off");
  property p_lock_hold; lock && !pll_wr && !$past(pll_wr) |=> lock; endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lock dropped by itself");
  c_idle: cover property (sleep_q && wake_now && idle_m);
  c_vec: cover property ($fell(halt) && rst_vec);
  c_lock: cover property ($rose(lock));
endmodule : slc_asserts
`default_nettype wire

// *** verification/test_sleep_mode_controller.sv ***
// self-checking bench: core end and controller end joined by the link
`timescale 1ns/10ps
`default_nettype none
`include "slc_defs.svh"
module test_sleep_mode_controller;
  localparam int LOCK_US = 2; // short lock time keeps the run brief
  localparam int LOCK_CYC = LOCK_US * 1000 / `SLC_CLK_NS;
  localparam logic [15:0] DEEP_SRC = 16'hc51f; // sources allowed in deep modes
  logic i_clk_sys, i_rst_n, sleep_exec, ctrl_wr, pll_wr, pll_data, pll_mux, cmp_off;
  logic [3:0] ctrl_data, lvl, fuses, ctrl_rd;
  logic [15:0] src;
  logic [2:0] rst_req;
  logic halted, isr, rstv, lock_rd, cpu_en, flash_en, io_en, osc_en, rc_en, pll_en, cmp_pw, sleeping;
  logic [3:0] refused [4] = '{4'h3, 4'h9, 4'hb, 4'h4}; // reserved codes, then unarmed
  int n_fail, num_checks, n;
  ////////////////////////////////////////////////////////////////////////////
  slc_if u_slc_if ();
  slc_core u_slc_core (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .bus(u_slc_if), .i_sleep_exec(sleep_exec),
    .i_ctrl_wr(ctrl_wr), .i_ctrl_data(ctrl_data), .i_pll_wr(pll_wr), .i_pll_data(pll_data), .i_pll_mux(pll_mux),
    .i_cmp_off(cmp_off), .i_src(src), .i_lvl(lvl), .i_rst(rst_req), .o_halted(halted), .o_isr(isr),
    .o_rst_vec(rstv), .o_ctrl_rd(ctrl_rd), .o_lock_rd(lock_rd));
  slc_device #(.PLL_LOCK_US(LOCK_US)) u_slc_device (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .bus(u_slc_if),
    .i_clock_select_fuses(fuses), .o_clk_cpu_en(cpu_en), .o_clk_flash_en(flash_en), .o_clk_io_en(io_en),
    .o_osc_en(osc_en), .o_rc_osc_en(rc_en), .o_pll_en(pll_en), .o_cmp_power(cmp_pw), .o_sleeping(sleeping));
  slc_asserts #(.PLL_LOCK_US(LOCK_US)) u_slc_asserts (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .sleep_instr(u_slc_if.sleep_instr), .ctrl_wr(u_slc_if.ctrl_wr), .ctrl_wdata(u_slc_if.ctrl_wdata),
    .pll_wr(u_slc_if.pll_wr), .pll_wdata(u_slc_if.pll_wdata), .cmp_off(u_slc_if.cmp_off), .src(u_slc_if.src),
    .lvl(u_slc_if.lvl), .rst(u_slc_if.rst), .ctrl_rd(u_slc_if.ctrl_rd), .lock(u_slc_if.lock),
    .halt(u_slc_if.halt), .resume(u_slc_if.resume), .rst_vec(u_slc_if.rst_vec));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic tally_and_finish;
    if (n_fail == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  task automatic cyc(input int k);
    repeat (k) @(negedge i_clk_sys);
  endtask : cyc
  task automatic wr_ctrl(input logic [3:0] d);
    ctrl_data = d;
    ctrl_wr = 1'b1;
    cyc(1);
    ctrl_wr = 1'b0;
  endtask : wr_ctrl
  task automatic wr_pll(input logic on, input logic mux);
    pll_data = on;
    pll_mux = mux;
    pll_wr = 1'b1;
    cyc(1);
    pll_wr = 1'b0;
  endtask : wr_pll
  // sleep in mode m with ignored traffic q held, then wake by s or r; len counts halted samples
  task automatic nap(input logic [2:0] m, input logic [15:0] q, input logic [15:0] s, input logic [2:0] r,
    input int len, input logic osc, input logic vec);
    int k;
    logic got_isr, got_vec;
    k = 0;
    got_isr = 1'b0;
    got_vec = 1'b0;
    src = q;
    wr_ctrl({m, 1'b1});
    sleep_exec = 1'b1;
    cyc(1);
    sleep_exec = 1'b0;
    cyc(12);
    chk("asleep", {halted, sleeping}, 16'h3);
    chk("clocks", {cpu_en, flash_en, io_en, osc_en, cmp_pw},
      {2'b00, m == `SLC_MODE_IDLE, osc, m == `SLC_MODE_IDLE && !cmp_off});
    src = q | s;
    rst_req = r;
    // bounded wait for the wake sequence to finish
    while (k < 40) begin
      cyc(1);
      got_isr |= isr;
      got_vec |= rstv;
      if (halted !== 1'b1) break;
      k++;
    end
    chk("wake", k[15:0], len[15:0]);
    chk("restart", {got_isr, got_vec}, {!vec, vec});
    // once the core runs again every clock is back; comparator follows its own bit
    chk("awake", {cpu_en, flash_en, io_en, osc_en, cmp_pw}, {4'hf, ~cmp_off});
    src = 16'h0;
    rst_req = 3'h0;
    wr_ctrl(4'h0); // disarm so a stray sleep cannot re-enter
    cyc(3);
  endtask : nap
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_clk_sys = 1'b0;
    forever #(`SLC_CLK_NS / 2) i_clk_sys = ~i_clk_sys;
  end
  // hang guard, well beyond the expected run length
  initial begin
    #(5000 * `SLC_CLK_NS);
    n_fail++;
    tally_and_finish();
  end
  initial begin
    i_rst_n = 1'b0;
    sleep_exec = 1'b0;
    ctrl_wr = 1'b0;
    ctrl_data = 4'h0;
    pll_wr = 1'b0;
    pll_data = 1'b0;
    pll_mux = 1'b0;
    cmp_off = 1'b1;
    src = 16'h0;
    lvl = 4'h1;
    rst_req = 3'h0;
    fuses = `SLC_CLOCK_SELECT_FUSES_RC;
    n_fail = 0;
    num_checks = 0;
    cyc(20);
    i_rst_n = 1'b1;
    cyc(2);
    chk("reset", {ctrl_rd, lock_rd, halted, pll_en, rc_en}, 16'h0);
    wr_pll(1'b1, 1'b0);
    cyc(3);
    chk("pll", {pll_en, rc_en}, 16'h2);
    // pll off before any sleep
    wr_pll(1'b0, 1'b0);
    cyc(4);
    wr_pll(1'b1, 1'b1);
    n = 0;
    while (lock_rd !== 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
    chk("lock", n[15:0], 16'(LOCK_CYC + 2));
    chk("rc", {pll_en, rc_en}, 16'h3);
    wr_pll(1'b0, 1'b1);
    cyc(4);
    chk("unlock", {lock_rd, rc_en}, 16'h0);
    wr_ctrl(4'h5);
    cyc(2);
    chk("ctrl", {12'h0, ctrl_rd}, 16'h5);
    foreach (refused[i]) begin
      wr_ctrl(refused[i]);
      sleep_exec = 1'b1;
      cyc(1);
      sleep_exec = 1'b0;
      cyc(4);
      chk("refused", {halted, cpu_en}, 16'h1);
    end
    for (int b = 0; b < 16; b++) begin
      if (b != 12) nap(`SLC_MODE_IDLE, 16'h1000, 16'h1 << b, 3'h0, 6, 1'b1, 1'b0);
    end
    for (int m = 2; m < 4; m++) begin
      for (int b = 0; b < 16; b++) begin
        if (DEEP_SRC[b]) nap(3'(m), 16'h2ae0, 16'h1 << b, 3'h0, 16, 1'b0, 1'b0);
      end
    end
    for (int r = 0; r < 3; r++) nap(`SLC_MODE_PDOWN, 16'h0, 16'h0, 3'h1 << r, 16, 1'b0, 1'b1);
    nap(`SLC_MODE_STBY, 16'h2ae0, 16'h4000, 3'h0, 16, 1'b0, 1'b0);
    // crystal source for the standby modes
    fuses = 4'hf;
    nap(`SLC_MODE_STBY, 16'h2ae0, 16'h4000, 3'h0, 12, 1'b1, 1'b0);
    nap(`SLC_MODE_XSTBY, 16'h2ae0, 16'h8000, 3'h0, 12, 1'b1, 1'b0);
    cmp_off = 1'b0;
    nap(`SLC_MODE_IDLE, 16'h0, 16'h1000, 3'h0, 6, 1'b1, 1'b0);
    tally_and_finish();
  end
endmodule : test_sleep_mode_controller
`default_nettype wire
